/* File: rtl/lfs_top.sv */
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lfs_consts.svh"


module lfs_top #(
	parameter int ADDR_W = 8,
	parameter int PWM_MIN_CYC = `LFS_PWM_MIN_CYC,
	parameter int TICK_DIV = `LFS_TICK_DIV
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fault flags: short, open, supply low
	input wire logic [2:0] fault_flag_inputs,
	// override switch, active low
	input wire logic override_switch_in,
	// load and indicators
	output logic load_control_out,
	output logic pwm_load_out,
	output logic condition_event_n,
	output logic ok_lamp_n,
	output logic overcurrent_lamp_n,
	output logic open_lamp_n,
	output logic supply_lamp_n,
	output logic hw_fault_lamp,
	output logic sense_inhibit_out
);

	lfs_pkg::lfs_state_t r_reg;
	lfs_pkg::lfs_state_t r_next;

	logic dbn_active;
	logic dbn_fire;
	logic short_flag_in;
	logic fault_now;
	logic impossible;
	logic setup_ph;
	logic wr_acc;
	logic drive_ok;
	logic [5:0] ev_set;
	logic [5:0] ev_clr;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a[7:0] == off);
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, `LFS_OFF_CTRL) || hit(a, `LFS_OFF_STATUS) ||
			hit(a, `LFS_OFF_EVENT) || hit(a, `LFS_OFF_MASK) ||
			hit(a, `LFS_OFF_PRIO) || hit(a, `LFS_OFF_PORTMODE) ||
			hit(a, `LFS_OFF_PWM_PER) || hit(a, `LFS_OFF_PWM_DUTY);
	endfunction : mapped

	function automatic logic [15:0] clamp_per(input logic [31:0] w);
		clamp_per = (w[15:0] < 16'(PWM_MIN_CYC)) ? 16'(PWM_MIN_CYC) : w[15:0];
	endfunction : clamp_per

	lfs_debounce #(
		.TICK_DIV(TICK_DIV),
		.PRESCALE(`LFS_PRESCALE),
		.COUNT(`LFS_TMR_COUNT)
	) u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.override_switch_in(override_switch_in),
		.active_out(dbn_active),
		.fire_out(dbn_fire)
	);

	assign short_flag_in = fault_flag_inputs[`LFS_FLAG_SHORT];
	assign fault_now = ~(~|fault_flag_inputs);
	assign impossible = short_flag_in && fault_flag_inputs[`LFS_FLAG_OPEN];
	assign setup_ph = psel && !penable;
	assign pready = psel && penable;
	assign pslverr = pready && !mapped(paddr);
	assign wr_acc = pready && pwrite && mapped(paddr);

	always_comb begin
		r_next = r_reg;
		ev_set = 6'h00;
		ev_clr = 6'h00;
		drive_ok = 1'b0;

		// apb writes
		if (wr_acc) begin
			if (hit(paddr, `LFS_OFF_CTRL)) begin
				r_next.ctrl = pwdata[1:0];
			end
			if (hit(paddr, `LFS_OFF_EVENT)) begin
				ev_clr = pwdata[5:0];
			end
			if (hit(paddr, `LFS_OFF_MASK)) begin
				r_next.ev_mask = pwdata[5:0];
			end
			if (hit(paddr, `LFS_OFF_PRIO)) begin
				r_next.ev_prio = pwdata[7:0];
			end
			if (hit(paddr, `LFS_OFF_PWM_PER)) begin
				r_next.pwm_per = clamp_per(pwdata);
			end
			if (hit(paddr, `LFS_OFF_PWM_DUTY)) begin
				r_next.pwm_duty = pwdata[15:0];
			end
		end

		// condition handling
		r_next.cond_n = !fault_now;
		unique case (r_reg.mode)
			lfs_pkg::LFS_RUN: begin
				if (fault_now) begin
					r_next.cause = fault_flag_inputs;
					r_next.mode = impossible ? lfs_pkg::LFS_HALT : lfs_pkg::LFS_FAULT;
				end
			end
			lfs_pkg::LFS_FAULT: begin
				r_next.cause = fault_flag_inputs;
				if (!fault_now) begin
					r_next.mode = lfs_pkg::LFS_RUN;
				end else if (impossible) begin
					r_next.mode = lfs_pkg::LFS_HALT;
				end
			end
			lfs_pkg::LFS_HALT: begin
				if (!fault_now) begin
					r_next.mode = lfs_pkg::LFS_RUN;
				end
			end
			default: begin
				r_next.mode = lfs_pkg::LFS_HALT;
			end
		endcase

		// override
		if (override_switch_in) begin
			r_next.override_act = 1'b0;
		end else if (dbn_fire && r_reg.ev_mask[`LFS_EV_TMO]) begin
			r_next.override_act = 1'b1;
		end
		r_next.dbn_prev = dbn_active;

		// events, set wins over clear
		ev_set[`LFS_EV_OVR] = dbn_active && !r_reg.dbn_prev;
		ev_set[`LFS_EV_COND] = r_reg.cond_n && fault_now;
		ev_set[`LFS_EV_TMO] = dbn_fire;
		r_next.ev_pend = (r_reg.ev_pend & ~ev_clr) | (ev_set & r_reg.ev_mask);

		// drive and lamps
		drive_ok = (r_next.mode == lfs_pkg::LFS_RUN) ||
			(r_next.mode == lfs_pkg::LFS_FAULT && r_next.override_act &&
			r_reg.ev_prio[`LFS_PRIO_TMO]);
		drive_ok = drive_ok && r_reg.ctrl[`LFS_CTRL_EN];
		r_next.load_out = drive_ok && !r_reg.ctrl[`LFS_CTRL_PWM];
		if (r_reg.pwm_cnt >= r_reg.pwm_per - 16'h0001) begin
			r_next.pwm_cnt = 16'h0000;
		end else begin
			r_next.pwm_cnt = r_reg.pwm_cnt + 16'h0001;
		end
		r_next.pwm_out = drive_ok && r_reg.ctrl[`LFS_CTRL_PWM] &&
			(r_reg.pwm_cnt < r_reg.pwm_duty);
		r_next.ok_n = (r_next.mode != lfs_pkg::LFS_RUN);
		r_next.oc_n = !(r_next.mode == lfs_pkg::LFS_FAULT &&
			r_next.cause[`LFS_FLAG_SHORT]);
		r_next.open_n = !(r_next.mode == lfs_pkg::LFS_FAULT &&
			r_next.cause[`LFS_FLAG_OPEN]);
		r_next.supply_n = !(r_next.mode == lfs_pkg::LFS_FAULT &&
			r_next.cause[`LFS_FLAG_SUPPLY]);
		r_next.hw_lamp = (r_next.mode == lfs_pkg::LFS_HALT);
		r_next.inhibit = r_next.override_act;

		// read data captured in setup phase
		if (setup_ph) begin
			r_next.prdata = 32'h0000_0000;
			if (hit(paddr, `LFS_OFF_CTRL)) begin
				r_next.prdata[1:0] = r_reg.ctrl;
			end
			if (hit(paddr, `LFS_OFF_STATUS)) begin
				r_next.prdata[7:0] = {r_reg.cond_n, dbn_active, r_reg.override_act,
					r_reg.mode, fault_flag_inputs};
			end
			if (hit(paddr, `LFS_OFF_EVENT)) begin
				r_next.prdata[5:0] = r_reg.ev_pend;
			end
			if (hit(paddr, `LFS_OFF_MASK)) begin
				r_next.prdata[5:0] = r_reg.ev_mask;
			end
			if (hit(paddr, `LFS_OFF_PRIO)) begin
				r_next.prdata[7:0] = r_reg.ev_prio;
			end
			if (hit(paddr, `LFS_OFF_PORTMODE)) begin
				r_next.prdata[7:0] = `LFS_PORTMODE_VAL;
			end
			if (hit(paddr, `LFS_OFF_PWM_PER)) begin
				r_next.prdata[15:0] = r_reg.pwm_per;
			end
			if (hit(paddr, `LFS_OFF_PWM_DUTY)) begin
				r_next.prdata[15:0] = r_reg.pwm_duty;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{
				mode: lfs_pkg::LFS_RUN,
				cause: 3'h0,
				ctrl: `LFS_CTRL_RST,
				ev_pend: 6'h00,
				ev_mask: `LFS_MASK_RST,
				ev_prio: `LFS_PRIO_RST,
				pwm_per: 16'(PWM_MIN_CYC),
				pwm_duty: `LFS_PWM_DUTY_RST,
				pwm_cnt: 16'h0000,
				override_act: 1'b0,
				dbn_prev: 1'b0,
				cond_n: 1'b1,
				load_out: 1'b0,
				pwm_out: 1'b0,
				ok_n: 1'b1,
				oc_n: 1'b1,
				open_n: 1'b1,
				supply_n: 1'b1,
				hw_lamp: 1'b0,
				inhibit: 1'b0,
				prdata: 32'h0000_0000
			};
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs, pin directions fixed
	assign prdata = r_reg.prdata;
	assign load_control_out = r_reg.load_out;
	assign pwm_load_out = r_reg.pwm_out;
	assign condition_event_n = r_reg.cond_n;
	assign ok_lamp_n = r_reg.ok_n;
	assign overcurrent_lamp_n = r_reg.oc_n;
	assign open_lamp_n = r_reg.open_n;
	assign supply_lamp_n = r_reg.supply_n;
	assign hw_fault_lamp = r_reg.hw_lamp;
	assign sense_inhibit_out = r_reg.inhibit;

	// checks
	nor_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|fault_flag_inputs) |=> !condition_event_n)
		else $error("condition event not low after a flag");
	fault_withdraw_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|fault_flag_inputs) && !r_reg.override_act && override_switch_in
		|=> !load_control_out && !pwm_load_out)
		else $error("load drive kept during a fault");
	no_fault_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(|fault_flag_inputs) && r_reg.mode != lfs_pkg::LFS_FAULT
		&& r_reg.ctrl == 2'h1 |=> load_control_out && !ok_lamp_n)
		else $error("no drive or ok lamp without a fault");
	short_lamp_a: assert property (@(posedge pclk) disable iff (!presetn)
		short_flag_in && !fault_flag_inputs[`LFS_FLAG_OPEN] && r_reg.mode != lfs_pkg::LFS_HALT
		|=> !overcurrent_lamp_n && ok_lamp_n)
		else $error("short did not light overcurrent lamp");
	recover_path_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_reg.mode == lfs_pkg::LFS_FAULT ##1 !(|fault_flag_inputs)
		|=> !ok_lamp_n && overcurrent_lamp_n)
		else $error("lamps not restored after fault cleared");
	hw_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		impossible |=> hw_fault_lamp && !load_control_out && ok_lamp_n)
		else $error("impossible flags did not halt");
	inhibit_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sense_inhibit_out) |-> $past(dbn_fire) && !$past(override_switch_in))
		else $error("sense inhibit rose without debounce timeout");
	pwm_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_reg.pwm_per >= 16'(PWM_MIN_CYC))
		else $error("pwm period below minimum");
	apb_resp_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready && psel && penable)
		else $error("error response outside access phase");

endmodule : lfs_top

/* File: rtl/lfs_consts.svh */
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// register byte offsets
`define LFS_OFF_CTRL 8'h00
`define LFS_OFF_STATUS 8'h04
`define LFS_OFF_EVENT 8'h08
`define LFS_OFF_MASK 8'h0C
`define LFS_OFF_PRIO 8'h10
`define LFS_OFF_PORTMODE 8'h14
`define LFS_OFF_PWM_PER 8'h18
`define LFS_OFF_PWM_DUTY 8'h1C

// reset values
`define LFS_CTRL_RST 2'h1
`define LFS_MASK_RST 6'h2C
`define LFS_PRIO_RST 8'h08
`define LFS_PORTMODE_VAL 8'h07
`define LFS_PWM_DUTY_RST 16'h0C35

// field positions
`define LFS_CTRL_EN 0
`define LFS_CTRL_PWM 1
`define LFS_FLAG_SHORT 0
`define LFS_FLAG_OPEN 1
`define LFS_FLAG_SUPPLY 2
`define LFS_EV_OVR 2
`define LFS_EV_COND 3
`define LFS_EV_TMO 5
`define LFS_PRIO_TMO 3

// timing
`define LFS_CLK_HZ 125000000
`define LFS_PWM_FMAX_HZ 20000
`define LFS_PWM_MIN_CYC ((`LFS_CLK_HZ + `LFS_PWM_FMAX_HZ - 1) / `LFS_PWM_FMAX_HZ)
`define LFS_DEBOUNCE_US 11000
`define LFS_PRESCALE 64
`define LFS_TMR_COUNT 256
`define LFS_TICK_DIV ((`LFS_CLK_HZ / 1000000) * `LFS_DEBOUNCE_US / (`LFS_PRESCALE * `LFS_TMR_COUNT))

`endif

/* File: rtl/lfs_pkg.sv */
package lfs_pkg;

	typedef enum logic [1:0] {
		LFS_RUN = 2'b00,
		LFS_FAULT = 2'b01,
		LFS_HALT = 2'b11
	} lfs_mode_t;

	typedef struct packed {
		logic active;
		logic fire;
		logic sw_prev;
		logic [15:0] div;
		logic [6:0] pre;
		logic [8:0] cnt;
	} lfs_dbn_state_t;

	typedef struct packed {
		lfs_mode_t mode;
		logic [2:0] cause;
		logic [1:0] ctrl;
		logic [5:0] ev_pend;
		logic [5:0] ev_mask;
		logic [7:0] ev_prio;
		logic [15:0] pwm_per;
		logic [15:0] pwm_duty;
		logic [15:0] pwm_cnt;
		logic override_act;
		logic dbn_prev;
		logic cond_n;
		logic load_out;
		logic pwm_out;
		logic ok_n;
		logic oc_n;
		logic open_n;
		logic supply_n;
		logic hw_lamp;
		logic inhibit;
		logic [31:0] prdata;
	} lfs_state_t;

endpackage : lfs_pkg

/* File: rtl/lfs_debounce.sv */
`timescale 1ns/1ps
`include "lfs_consts.svh"

module lfs_debounce #(
	parameter int TICK_DIV = `LFS_TICK_DIV,
	parameter int PRESCALE = `LFS_PRESCALE,
	parameter int COUNT = `LFS_TMR_COUNT
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// switch, active low
	input wire logic override_switch_in,
	// timer state
	output logic active_out,
	output logic fire_out
);

	lfs_pkg::lfs_dbn_state_t r_reg;
	lfs_pkg::lfs_dbn_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.sw_prev = override_switch_in;
		r_next.fire = 1'b0;
		if (!r_reg.active) begin
			if (r_reg.sw_prev && !override_switch_in) begin
				r_next.active = 1'b1;
				r_next.div = 16'h0000;
				r_next.pre = 7'h00;
				r_next.cnt = 9'h000;
			end
		end else if (override_switch_in) begin
			r_next.active = 1'b0;
		end else if (r_reg.div == 16'(TICK_DIV - 1)) begin
			r_next.div = 16'h0000;
			if (r_reg.pre == 7'(PRESCALE - 1)) begin
				r_next.pre = 7'h00;
				if (r_reg.cnt == 9'(COUNT - 1)) begin
					r_next.active = 1'b0;
					r_next.fire = 1'b1;
				end else begin
					r_next.cnt = r_reg.cnt + 9'h001;
				end
			end else begin
				r_next.pre = r_reg.pre + 7'h01;
			end
		end else begin
			r_next.div = r_reg.div + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{active: 1'b0, fire: 1'b0, sw_prev: 1'b1, div: 16'h0000,
				pre: 7'h00, cnt: 9'h000};
		end else begin
			r_reg <= r_next;
		end
	end

	assign active_out = r_reg.active;
	assign fire_out = r_reg.fire;

	fire_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		fire_out |-> $past(active_out) && !$past(override_switch_in) && !active_out)
		else $error("timeout fired without a held switch");
	cancel_path_a: assert property (@(posedge pclk) disable iff (!presetn)
		active_out && override_switch_in |=> !active_out && !fire_out)
		else $error("released switch did not cancel debounce");

endmodule : lfs_debounce

/* File: tb/lfs_load_model.sv */
`timescale 1ns/1ps

module lfs_load_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// commanded load conditions
	input wire logic short_cmd,
	input wire logic open_cmd,
	input wire logic low_cmd,
	// from supervisor
	input wire logic load_control_out,
	input wire logic sense_inhibit_out,
	// flags to supervisor
	output logic [2:0] fault_flag_inputs
);
	logic trip_reg;

	// predriver overcurrent latch, cleared by a low control input while short_cmd is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_reg <= 1'b0;
		end else if (short_cmd && !sense_inhibit_out) begin
			trip_reg <= 1'b1;
		end else if (!load_control_out && !short_cmd) begin
			trip_reg <= 1'b0;
		end
	end

	// open-load and supply sources are low in normal use
	assign fault_flag_inputs = {low_cmd, open_cmd, trip_reg};
endmodule : lfs_load_model

/* File: tb/lfs_top_tb.sv */
`timescale 1ns/1ps
`include "lfs_consts.svh"

module lfs_top_tb;
	localparam int TD = 1;
	localparam int DBN = TD * `LFS_PRESCALE * `LFS_TMR_COUNT;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, override_switch_in;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic load_control_out, pwm_load_out, condition_event_n, ok_lamp_n;
	logic overcurrent_lamp_n, open_lamp_n, supply_lamp_n, hw_fault_lamp, sense_inhibit_out;
	logic [2:0] fault_flag_inputs, f;
	logic short_cmd, open_cmd, low_cmd;
	logic [7:0] outv;
	logic [15:0] e;
	logic [32:0] rq[$];
	logic [15:0] oq[$];
	int mismatches = 0;
	int tests_run = 0;
	int hi;

	assign outv = {load_control_out, ok_lamp_n, overcurrent_lamp_n, open_lamp_n,
		supply_lamp_n, hw_fault_lamp, condition_event_n, sense_inhibit_out};

	always #4 pclk = ~pclk;

	lfs_top #(.ADDR_W(8), .PWM_MIN_CYC(8), .TICK_DIV(TD)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fault_flag_inputs, .override_switch_in, .load_control_out,
		.pwm_load_out, .condition_event_n, .ok_lamp_n, .overcurrent_lamp_n, .open_lamp_n,
		.supply_lamp_n, .hw_fault_lamp, .sense_inhibit_out
	);

	lfs_load_model partner (
		.pclk, .presetn, .short_cmd, .open_cmd, .low_cmd, .load_control_out,
		.sense_inhibit_out, .fault_flag_inputs
	);

	task check(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task print_verdict;
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task w(input int n);
		repeat (n) @(posedge pclk);
	endtask : w

	// one apb transfer, waits for pready under a bound
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rd(input logic [7:0] a, input logic [32:0] x);
		rq.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task eo(input logic [7:0] v, input logic [7:0] m);
		oq.push_back({m, v});
	endtask : eo

	task fl(input logic [2:0] v);
		{low_cmd, open_cmd, short_cmd} <= v;
		w(4 + $urandom_range(0, 3));
	endtask : fl

	// read results at the access edge
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rq.size() > 0) begin
			check({pslverr, prdata}, rq.pop_front());
		end
	end

	// output notes are compared on the next falling edge
	always @(negedge pclk) begin
		if (oq.size() > 0) begin
			e = oq.pop_front();
			check({25'h0, outv & e[15:8]}, {25'h0, e[7:0] & e[15:8]});
		end
	end

	initial begin
		w(3 * DBN + 20000);
		mismatches++;
		print_verdict();
	end

	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		override_switch_in = 1'b1;
		{low_cmd, open_cmd, short_cmd} = 3'h0;
		void'($urandom(86));
		w(6);
		presetn <= 1'b1;
		w(2);
		eo(8'hBA, 8'hFF);
		rd(`LFS_OFF_CTRL, 33'h1);
		rd(`LFS_OFF_MASK, 33'h2C);
		rd(`LFS_OFF_PRIO, 33'h08);
		rd(`LFS_OFF_EVENT, 33'h0);
		rd(`LFS_OFF_STATUS, 33'h80);
		rd(`LFS_OFF_PWM_DUTY, 33'h0C35);
		rd(8'h20, 33'h100000000);
		r = $urandom;
		apb(1'b1, `LFS_OFF_PORTMODE, r);
		rd(`LFS_OFF_PORTMODE, 33'h07);
		apb(1'b1, `LFS_OFF_MASK, r);
		rd(`LFS_OFF_MASK, {27'h0, r[5:0]});
		apb(1'b1, `LFS_OFF_MASK, 32'h2C);
		for (int i = 1; i < 8; i++) begin
			f = i[2:0];
			fl(f);
			if (f[0] && f[1]) begin
				eo(8'h04, 8'h86);
				rd(`LFS_OFF_STATUS, {28'h0, 2'b11, f});
				fl(3'h1);
				eo(8'h04, 8'h86);
			end else begin
				eo({2'b01, ~f[0], ~f[1], ~f[2], 3'h0}, 8'hFF);
				rd(`LFS_OFF_STATUS, {28'h0, 2'b01, f});
			end
			fl(3'h0);
			eo(8'hBA, 8'hFF);
		end
		apb(1'b1, `LFS_OFF_EVENT, 32'h3F);
		rd(`LFS_OFF_EVENT, 33'h0);
		override_switch_in <= 1'b0;
		w(20);
		rd(`LFS_OFF_STATUS, 33'hC0);
		override_switch_in <= 1'b1;
		w(DBN + 20);
		eo(8'hBA, 8'hFF);
		rd(`LFS_OFF_STATUS, 33'h80);
		apb(1'b1, `LFS_OFF_EVENT, 32'h3F);
		override_switch_in <= 1'b0;
		w(DBN - 20);
		eo(8'hBA, 8'hFF);
		w(40);
		eo(8'hBB, 8'hFF);
		rd(`LFS_OFF_EVENT, 33'h24);
		short_cmd <= 1'b1;
		w(4);
		eo(8'hBB, 8'hFF);
		short_cmd <= 1'b0;
		override_switch_in <= 1'b1;
		w(4);
		eo(8'hBA, 8'hFF);
		apb(1'b1, `LFS_OFF_EVENT, 32'h24);
		rd(`LFS_OFF_EVENT, 33'h0);
		apb(1'b1, `LFS_OFF_PWM_PER, 32'h2);
		rd(`LFS_OFF_PWM_PER, 33'h8);
		apb(1'b1, `LFS_OFF_PWM_DUTY, 32'h3);
		apb(1'b1, `LFS_OFF_CTRL, 32'h3);
		w(8);
		hi = 0;
		repeat (80) begin
			@(negedge pclk);
			hi += int'(pwm_load_out === 1'b1);
		end
		check(33'(hi), 33'd30);
		w(2);
		print_verdict();
	end
endmodule : lfs_top_tb
